// [dv/opm_irq_src.sv]
// partner model: chipset and interrupt controller raising management events
// assumes it shares the block's clock; pin idles high like a pulled-up line
`timescale 1ns/100ps
module opm_irq_src (
   input  wire logic ref_clk_i,
   output logic      mgmt_int_n_o,
   output logic      mgmt_msg_o
);
   initial
   begin
      mgmt_int_n_o = 1'b1;
      mgmt_msg_o   = 1'b0;
   end
   // controller message, one clean cycle
   task automatic send_msg();
      @(posedge ref_clk_i);
      mgmt_msg_o <= 1'b1;
      @(posedge ref_clk_i);
      mgmt_msg_o <= 1'b0;
   endtask
   // pin held low past the two-stage sync, then back to idle high
   task automatic pull_pin();
      @(posedge ref_clk_i);
      mgmt_int_n_o <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      mgmt_int_n_o <= 1'b1;
   endtask
endmodule // opm_irq_src

// [dv/testbench.sv]
// self-checking bench for the operating-mode control block
// assumes one 25 MHz clock; commands are single-cycle pulses
`timescale 1ns/100ps
module testbench;
   logic               ref_clk_i = 1'b0;
   logic               rst_n_i   = 1'b0;
   logic [4:0]         cmd       = '0;
   logic               cs_d      = 1'b0;
   logic               pin_n;
   logic               msg;
   opm_pkg::opm_req_s  req       = '0;
   opm_pkg::opm_rsp_s  rsp;
   opm_pkg::opm_mode_e mode;
   logic               v86, sv, rs, sp;
   int                 err_total = 0;
   int                 cmp_count = 0;
   always #20 ref_clk_i = ~ref_clk_i;
   opm_irq_src pt (.ref_clk_i(ref_clk_i), .mgmt_int_n_o(pin_n), .mgmt_msg_o(msg));
   opm_mode_ctrl dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mgmt_int_n_i(pin_n),
      .mgmt_msg_i(msg), .prot_enter_i(cmd[0]), .mgmt_resume_i(cmd[1]), .v86_set_i(cmd[2]),
      .v86_clr_i(cmd[3]), .cs_d_load_i(cmd[4]), .cs_d_i(cs_d), .req_i(req), .mode_o(mode),
      .v86_o(v86), .ctx_save_o(sv), .ctx_restore_o(rs), .mgmt_space_o(sp), .rsp_o(rsp));
   task automatic final_report();
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bits: 0 prot enter, 1 resume, 2 v86 set, 3 v86 clr, 4 cs_d load
   task automatic pulse(input int b);
      @(posedge ref_clk_i);
      cmd[b] <= 1'b1;
      @(posedge ref_clk_i);
      cmd[b] <= 1'b0;
      #1;
   endtask
   task automatic ask(input logic [15:0] s, input logic [31:0] o, b, input logic a, p);
      @(posedge ref_clk_i);
      req <= '{1'b1, s, o, b, a, p};
      @(posedge ref_clk_i);
      req.valid <= 1'b0;
      #1;
   endtask
   task automatic chk_rsp(input logic [31:0] lin, input logic f, a, p);
      check({31'b0, rsp.valid}, 1);
      check(rsp.linear, lin);
      check({29'b0, rsp.fault, rsp.addr32, rsp.oper32}, {29'b0, f, a, p});
   endtask
   task automatic chk_mode(input opm_pkg::opm_mode_e m, input logic [3:0] fl);
      check({30'b0, mode}, {30'b0, m});
      check({28'b0, v86, sv, rs, sp}, {28'b0, fl});
   endtask
   task automatic t_reset();
      chk_mode(opm_pkg::OPM_REAL, 4'h0);
      check({31'b0, rsp.valid}, 0);
   endtask
   task automatic t_real();
      ask(16'h1000, 32'h0000_1234, 0, 0, 0);
      chk_rsp(32'h0001_1234, 0, 0, 0);
      ask(16'h1000, 32'h0001_0000, 0, 1, 0);
      // a 32-bit override keeps the full offset, so the base still adds on top
      chk_rsp(32'h0002_0000, 1, 1, 0);
      ask(16'h0000, 32'h0000_FFFF, 0, 0, 1);
      chk_rsp(32'h0000_FFFF, 0, 0, 1);
      pulse(1);
      chk_mode(opm_pkg::OPM_REAL, 4'h0);
      pulse(2);
      chk_mode(opm_pkg::OPM_REAL, 4'h0);
   endtask
   task automatic t_prot();
      pulse(0);
      chk_mode(opm_pkg::OPM_PROT, 4'h0);
      cs_d <= 1'b1;
      pulse(4);
      ask(16'h0008, 32'hFFFF_FFF0, 0, 0, 0);
      chk_rsp(32'hFFFF_FFF0, 0, 1, 1);
      ask(16'h0008, 32'h0000_FFFF, 32'h0000_1000, 1, 0);
      chk_rsp(32'h0001_0FFF, 0, 0, 1);
      ask(16'hFFF8, 32'h0000_0020, 32'h0010_0000, 0, 0);
      chk_rsp(32'h0010_0020, 0, 1, 1);
      ask(16'hFFFC, 32'h0000_0020, 32'h0010_0000, 0, 0);
      check({31'b0, rsp.fault}, 1);
      pulse(0);
      chk_mode(opm_pkg::OPM_PROT, 4'h0);
   endtask
   task automatic t_mgmt_msg();
      pulse(2);
      chk_mode(opm_pkg::OPM_PROT, 4'h8);
      pt.send_msg();
      #1;
      chk_mode(opm_pkg::OPM_MGMT, 4'h5);
      pt.send_msg();
      #1;
      chk_mode(opm_pkg::OPM_MGMT, 4'h1);
      ask(16'h0010, 32'h0000_0004, 0, 0, 0);
      chk_rsp(32'h0003_0104, 0, 0, 0);
      pulse(1);
      chk_mode(opm_pkg::OPM_PROT, 4'hA);
      pulse(3);
      ask(16'h0008, 32'h0000_0010, 0, 0, 0);
      chk_rsp(32'h0000_0010, 0, 1, 1);
   endtask
   task automatic t_mgmt_pin();
      int n;
      n = 0;
      fork
         pt.pull_pin();
         while (mode !== opm_pkg::OPM_MGMT && n < 8)
         begin
            @(posedge ref_clk_i);
            #1;
            n++;
         end
      join
      if (n >= 8)
      begin
         err_total++;
         final_report();
      end
      // pin change, two sync edges, then the mode edge: seen on the fourth
      check(n, 4);
      pulse(1);
      chk_mode(opm_pkg::OPM_PROT, 4'h2);
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk_i);
      #1;
      t_reset();
      rst_n_i <= 1'b1;
      t_real();
      t_prot();
      t_mgmt_msg();
      t_mgmt_pin();
      final_report();
   end
endmodule // testbench

// [hdl/opm_mode_ctrl.sv]
// operating-mode tracking, management-mode entry/exit and address sizing
// assumes the pipeline gives one-cycle command pulses and a sync clock domain
// except the management pin, which is asynchronous
`timescale 1ns/100ps
`include "opm_cfg.svh"

// Summary of operation
// - reset always leaves the block in real-address mode
// - one protected-enable command moves real mode to protected mode
// - management pin or controller message enters management mode
// - entry saves full context and selects the private management space
// - resume restores exactly the saved mode, task attribute and sizes
// - management space uses real-style base plus offset addressing
// - protected mode allows every memory model and feature
// - virtual-8086 is a task flag inside protected mode only
// - real mode offers only the real-address memory model
// - physical space is bytes from zero to four gigabytes minus one
// - each selector plus offset becomes a linear address internally
// - selector index above 16382 reported as a fault
// - offset width is 32 or 16 bits by address size
// - 16-bit addressing caps offsets at FFFFH, operands default 16-bit
// - prefixes flip address or operand size for one instruction only
// - protected mode defaults come from the code segment descriptor bit
// - real mode defaults to 16-bit address and operand size
// - real mode 32-bit override still caps addresses at 0000FFFFH
module opm_mode_ctrl (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              mgmt_int_n_i,
   input  wire logic              mgmt_msg_i,
   input  wire logic              prot_enter_i,
   input  wire logic              mgmt_resume_i,
   input  wire logic              v86_set_i,
   input  wire logic              v86_clr_i,
   input  wire logic              cs_d_load_i,
   input  wire logic              cs_d_i,
   input  wire opm_pkg::opm_req_s req_i,
   output opm_pkg::opm_mode_e     mode_o,
   output logic                   v86_o,
   output logic                   ctx_save_o,
   output logic                   ctx_restore_o,
   output logic                   mgmt_space_o,
   output opm_pkg::opm_rsp_s      rsp_o
);
   // pin sync: first stage read only by the second
   logic                   pin_s1_reg;
   logic                   pin_s2_reg;
   logic                   pin_prev_reg;
   opm_pkg::opm_mode_e     mode_reg;
   opm_pkg::opm_mode_e     mode_next;
   logic                   v86_reg;
   logic                   v86_next;
   logic                   cs_d_reg;
   logic                   cs_d_next;
   opm_pkg::opm_ctx_s      saved_reg;
   logic                   save_reg;
   logic                   restore_reg;
   opm_pkg::opm_rsp_s      rsp_reg;
   opm_pkg::opm_rsp_s      rsp_next;

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pin_s1_reg   <= 1'b1;
         pin_s2_reg   <= 1'b1;
         pin_prev_reg <= 1'b1;
      end
      else
      begin
         pin_s1_reg   <= mgmt_int_n_i;
         pin_s2_reg   <= pin_s1_reg;
         pin_prev_reg <= pin_s2_reg;
      end
   end

   // mode sequencing
   wire in_mgmt      = (mode_reg == opm_pkg::OPM_MGMT);
   wire pin_fall     = pin_prev_reg & ~pin_s2_reg;
   wire mgmt_event   = (pin_fall | mgmt_msg_i) & ~in_mgmt;
   wire resume_ok    = mgmt_resume_i & in_mgmt;
   wire go_prot      = prot_enter_i & (mode_reg == opm_pkg::OPM_REAL);

   always_comb
   begin
      mode_next = mode_reg;
      v86_next  = v86_reg;
      cs_d_next = cs_d_reg;
      if (mgmt_event)
      begin
         mode_next = opm_pkg::OPM_MGMT;
         v86_next  = 1'b0;
         cs_d_next = 1'b0;
      end
      else if (resume_ok)
      begin
         mode_next = saved_reg.mode;
         v86_next  = saved_reg.v86;
         cs_d_next = saved_reg.cs_d;
      end
      else
      begin
         if (go_prot)
            mode_next = opm_pkg::OPM_PROT;
         // task attribute only meaningful in protected mode
         if (mode_reg == opm_pkg::OPM_PROT && v86_set_i)
            v86_next = 1'b1;
         else if (v86_clr_i || mode_reg != opm_pkg::OPM_PROT)
            v86_next = 1'b0;
         if (cs_d_load_i && mode_reg == opm_pkg::OPM_PROT)
            cs_d_next = cs_d_i;
         else if (mode_reg != opm_pkg::OPM_PROT)
            cs_d_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mode_reg    <= opm_pkg::OPM_REAL;
         v86_reg     <= 1'b0;
         cs_d_reg    <= 1'b0;
         saved_reg   <= '0;
         save_reg    <= 1'b0;
         restore_reg <= 1'b0;
      end
      else
      begin
         mode_reg    <= mode_next;
         v86_reg     <= v86_next;
         cs_d_reg    <= cs_d_next;
         save_reg    <= mgmt_event;
         restore_reg <= resume_ok;
         if (mgmt_event)
            saved_reg <= '{mode: mode_reg, v86: v86_reg, cs_d: cs_d_reg};
      end
   end

   // address sizing: prefix flips default for this request only
   wire v86_real_like = v86_reg & (mode_reg == opm_pkg::OPM_PROT);
   wire def32         = cs_d_reg & (mode_reg == opm_pkg::OPM_PROT) & ~v86_real_like;
   wire addr32        = def32 ^ req_i.asize_ovr;
   wire oper32        = def32 ^ req_i.osize_ovr;
   // real-style models cap at 64k even with a 32-bit override
   wire real_model    = (mode_reg != opm_pkg::OPM_PROT) | v86_real_like;
   wire [`OPM_ADDR_W-1:0] ofs_limit = (addr32 && !real_model) ?
                                      `OPM_OFS32_MAX : `OPM_OFS16_MAX;
   // 16-bit addressing uses only the low half of the offset
   wire [`OPM_ADDR_W-1:0] ofs_eff   = addr32 ? req_i.offset
                                      : {16'h0000, req_i.offset[15:0]};
   wire ofs_fault     = ofs_eff > ofs_limit;
   wire [13:0] seg_idx = req_i.selector[`OPM_SEG_IDX_MSB:`OPM_SEG_IDX_LSB];
   wire seg_fault     = ~real_model & (seg_idx > `OPM_MAX_SEG_IDX - 14'h0001);
   wire [`OPM_ADDR_W-1:0] real_base = {12'h000, req_i.selector, 4'h0};
   wire [`OPM_ADDR_W-1:0] base      = in_mgmt ? (`OPM_MGMT_BASE + real_base)
                                      : (real_model ? real_base : req_i.seg_base);
   // 32-bit wrap keeps the result inside the 4 GB byte space
   wire [`OPM_ADDR_W-1:0] lin       = base + ofs_eff;

   always_comb
   begin
      rsp_next        = '0;
      rsp_next.valid  = req_i.valid;
      rsp_next.linear = lin;
      rsp_next.fault  = req_i.valid & (ofs_fault | seg_fault);
      rsp_next.addr32 = addr32;
      rsp_next.oper32 = oper32;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rsp_reg <= '0;
      else
         rsp_reg <= rsp_next;
   end

   assign mode_o        = mode_reg;
   assign v86_o         = v86_reg;
   assign ctx_save_o    = save_reg;
   assign ctx_restore_o = restore_reg;
   assign mgmt_space_o  = in_mgmt;
   assign rsp_o         = rsp_reg;

   a_reset_real: assert property (@(posedge ref_clk_i)
      $rose(rst_n_i) |-> mode_reg == opm_pkg::OPM_REAL)
      else $error("mode not real after reset");
   a_prot_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      go_prot && !mgmt_event |=> mode_reg == opm_pkg::OPM_PROT)
      else $error("protected entry missed");
   a_mgmt_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mgmt_event |=> in_mgmt && save_reg)
      else $error("management entry missed");
   a_ctx_saved: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mgmt_event |=> saved_reg.mode == $past(mode_reg))
      else $error("context not saved");
   a_mode_restore: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      resume_ok |=> mode_reg == $past(saved_reg.mode) && restore_reg)
      else $error("mode not restored");
   a_v86_prot_only: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      v86_reg |-> mode_reg == opm_pkg::OPM_PROT)
      else $error("v86 outside protected");
   a_real_cap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && real_model && req_i.offset > 32'h0000_FFFF && addr32
      |=> rsp_reg.fault)
      else $error("real mode cap missed");
   a_real_size: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mode_reg == opm_pkg::OPM_REAL && !req_i.osize_ovr |=> !rsp_reg.oper32)
      else $error("real default not 16");
   a_one_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mode_reg != 2'b11)
      else $error("illegal mode");

   // sync chain: each stage one edge behind the one before
   a_sync_chain: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      pin_s2_reg == $past(pin_s1_reg))
      else $error("pin sync chain broken");

   // mode stability when no event applies
   a_real_stays: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mode_reg == opm_pkg::OPM_REAL && !go_prot && !mgmt_event
      |=> mode_reg == opm_pkg::OPM_REAL)
      else $error("real mode left without cause");

   a_prot_stays: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mode_reg == opm_pkg::OPM_PROT && !mgmt_event |=> mode_reg == opm_pkg::OPM_PROT)
      else $error("protected mode left without cause");

   a_mgmt_stays: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      in_mgmt && !resume_ok |=> in_mgmt)
      else $error("management left without resume");

   a_resume_ignored: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mgmt_resume_i && !in_mgmt && !mgmt_event && !go_prot
      |=> mode_reg == $past(mode_reg))
      else $error("resume acted outside management");

   // context pulses last one cycle
   a_save_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      save_reg |=> !save_reg)
      else $error("save pulse too long");

   a_restore_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      restore_reg |=> !restore_reg)
      else $error("restore pulse too long");

   a_v86_restore: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      resume_ok |=> v86_reg == $past(saved_reg.v86))
      else $error("task attribute not restored");

   a_csd_restore: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      resume_ok |=> cs_d_reg == $past(saved_reg.cs_d))
      else $error("default size not restored");

   a_csd_real_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mode_reg == opm_pkg::OPM_REAL |-> !cs_d_reg)
      else $error("real mode holds a 32-bit default");

   // management space addressing
   a_mgmt_base: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && in_mgmt |=> rsp_reg.linear >= `OPM_MGMT_BASE)
      else $error("management access below its space");

   a_mgmt_16bit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && in_mgmt && !req_i.osize_ovr |=> !rsp_reg.oper32)
      else $error("management default not 16");

   // prefixes and defaults
   a_real_aovr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && mode_reg == opm_pkg::OPM_REAL && req_i.asize_ovr |=> rsp_reg.addr32)
      else $error("real address override lost");

   a_real_oovr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && mode_reg == opm_pkg::OPM_REAL && req_i.osize_ovr |=> rsp_reg.oper32)
      else $error("real operand override lost");

   a_prot_def32: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && mode_reg == opm_pkg::OPM_PROT && !v86_reg && cs_d_reg
      && !req_i.asize_ovr |=> rsp_reg.addr32)
      else $error("protected 32-bit default lost");

   a_prot_def16: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && mode_reg == opm_pkg::OPM_PROT && !cs_d_reg
      && !req_i.asize_ovr |=> !rsp_reg.addr32)
      else $error("protected 16-bit default lost");

   a_v86_16bit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && v86_reg && !req_i.asize_ovr |=> !rsp_reg.addr32)
      else $error("v86 task not 16-bit");

   a_real_nofault: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && mode_reg == opm_pkg::OPM_REAL && !req_i.asize_ovr
      |=> !rsp_reg.fault)
      else $error("16-bit offset faulted");

   // segment index range in protected models
   a_seg_limit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && mode_reg == opm_pkg::OPM_PROT && !v86_reg
      && req_i.selector[15:2] == 14'h3FFF |=> rsp_reg.fault)
      else $error("segment index limit missed");

   a_seg_ok: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid && mode_reg == opm_pkg::OPM_PROT && !v86_reg && cs_d_reg
      && !req_i.asize_ovr && req_i.selector[15:2] != 14'h3FFF |=> !rsp_reg.fault)
      else $error("legal segment faulted");

   // answer follows request by one cycle
   a_valid_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req_i.valid |=> rsp_reg.valid)
      else $error("answer missing");

   a_idle_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !req_i.valid |=> !rsp_reg.valid && !rsp_reg.fault)
      else $error("answer without request");

   a_v86_cleared: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mgmt_event |=> !v86_reg)
      else $error("task attribute kept in management");
endmodule // opm_mode_ctrl

// [pkg/opm_cfg.svh]
// constants for the operating-mode and address-size control block
// assumes inclusion by opm_pkg and the design file only
`ifndef OPM_CFG_SVH
`define OPM_CFG_SVH
`define OPM_ADDR_W       32
`define OPM_SEL_W        16
`define OPM_OFS16_MAX    32'h0000_FFFF
`define OPM_OFS32_MAX    32'hFFFF_FFFF
`define OPM_MAX_SEG_IDX  14'h3FFF
`define OPM_SEG_IDX_MSB  15
`define OPM_SEG_IDX_LSB  2
`define OPM_MGMT_BASE    32'h0003_0000
`define OPM_SEG_SHIFT    4
`endif

// [pkg/opm_pkg.sv]
// types for the operating-mode and address-size control block
// assumes opm_cfg.svh sits on the include path
`include "opm_cfg.svh"
package opm_pkg;
   typedef enum logic [1:0] {
      OPM_REAL    = 2'b00,
      OPM_PROT    = 2'b01,
      OPM_MGMT    = 2'b10
   } opm_mode_e;

   // logical address request from the pipeline
   typedef struct packed {
      logic                       valid;
      logic [`OPM_SEL_W-1:0]      selector;
      logic [`OPM_ADDR_W-1:0]     offset;
      logic [`OPM_ADDR_W-1:0]     seg_base;
      logic                       asize_ovr;
      logic                       osize_ovr;
   } opm_req_s;

   // translated answer
   typedef struct packed {
      logic                       valid;
      logic [`OPM_ADDR_W-1:0]     linear;
      logic                       fault;
      logic                       addr32;
      logic                       oper32;
   } opm_rsp_s;

   // context held across management mode
   typedef struct packed {
      opm_mode_e                  mode;
      logic                       v86;
      logic                       cs_d;
   } opm_ctx_s;
endpackage
